/* File: rtl/ctz_pkg.sv */
// Purpose: constants, field layouts and lookup tables for the thermal-zone
//          configuration and status register bank.
// Assumes: 25 MHz system clock; temperatures in tenths of a degree C.
// Notes:   register fields are packed msb first as they sit in the byte.
package ctz_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CTZ_OFS_TIMING  = 8'h1a;
  localparam logic [7:0] CTZ_OFS_NTC_PRI = 8'h1c;
  localparam logic [7:0] CTZ_OFS_NTC_SEL = 8'h1d;
  localparam logic [7:0] CTZ_OFS_WARM    = 8'h1e;
  localparam logic [7:0] CTZ_OFS_COOL    = 8'h1f;
  localparam logic [7:0] CTZ_OFS_STATUS  = 8'h20;

  // ---------------------------------------------------------------
  // field layouts
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] power_good_threshold;
    logic       sys_reset_hold_sel;
    logic       low_power_exit_sel;
    logic       sys_pulldown_en;
    logic [1:0] precharge_to_fast_threshold;
  } ctz_timing_t;

  typedef struct packed {
    logic       thermistor_bypass;
    logic [1:0] charge_rate_divisor;
    logic [1:0] boost_hot_limit;
    logic       boost_cold_limit;
    logic       temp_threshold_first;
    logic       temp_threshold_sixth;
  } ctz_ntc_pri_t;

  typedef struct packed {
    logic [1:0] temp_threshold_second;
    logic [1:0] temp_threshold_third;
    logic [1:0] temp_threshold_fourth;
    logic [1:0] temp_threshold_fifth;
  } ctz_ntc_sel_t;

  // warm register: hot pair = warm, near pair = prewarm
  // cool register: hot pair = cool, near pair = precool
  typedef struct packed {
    logic [1:0] outer_voltage_adjust;
    logic [1:0] outer_current_adjust;
    logic [1:0] inner_voltage_adjust;
    logic [1:0] inner_current_adjust;
  } ctz_zone_adj_t;

  typedef struct packed {
    ctz_timing_t   timing;
    ctz_ntc_pri_t  ntc_pri;
    ctz_ntc_sel_t  ntc_sel;
    ctz_zone_adj_t warm;
    ctz_zone_adj_t cool;
  } ctz_regs_t;

  localparam ctz_regs_t CTZ_REGS_RESET = '{
    timing:  ctz_timing_t'(8'h00),
    ntc_pri: ctz_ntc_pri_t'(8'h0f),
    ntc_sel: ctz_ntc_sel_t'(8'h85),
    warm:    ctz_zone_adj_t'(8'h7f),
    cool:    ctz_zone_adj_t'(8'hdf)
  };

  // status inputs from the power stage, asynchronous to sys_clk_in
  typedef struct packed {
    logic vbus_above_pg;
    logic adc_oneshot_done;
    logic adc_continuous;
    logic thermal_reg;
    logic min_sys_reg;
    logic input_curr_reg;
    logic input_volt_reg;
    logic otg_curr_reg;
    logic otg_volt_reg;
    logic fast_timer_expired;
    logic trickle_timer_expired;
    logic precharge_timer_expired;
    logic watchdog_expired;
    logic forward_mode;
    logic otg_mode;
    logic [2:0] zone;
  } ctz_pins_t;

  typedef enum logic [2:0] {
    CTZ_ZONE_NORMAL  = 3'h0,
    CTZ_ZONE_COLD    = 3'h1,
    CTZ_ZONE_HOT     = 3'h2,
    CTZ_ZONE_COOL    = 3'h3,
    CTZ_ZONE_WARM    = 3'h4,
    CTZ_ZONE_PRECOOL = 3'h5,
    CTZ_ZONE_PREWARM = 3'h6
  } ctz_zone_t;

  // ---------------------------------------------------------------
  // lookup tables
  // ---------------------------------------------------------------
  typedef logic signed [10:0] ctz_temp_t;
  localparam ctz_temp_t TH1_TAB [2] = '{11'h7ce, 11'h000};
  localparam ctz_temp_t TH6_TAB [2] = '{11'h226, 11'h258};
  localparam ctz_temp_t TH2_TAB [4] = '{11'h032, 11'h04b, 11'h064, 11'h07d};
  localparam ctz_temp_t TH3_TAB [4] = '{11'h096, 11'h0af, 11'h0c8, 11'h0e1};
  localparam ctz_temp_t TH4_TAB [4] = '{11'h145, 11'h15e, 11'h177, 11'h190};
  localparam ctz_temp_t TH5_TAB [4] = '{11'h1a9, 11'h1c2, 11'h1db, 11'h1f4};
  localparam ctz_temp_t OTG_HOT_TAB  [4] = '{11'h226, 11'h258, 11'h28a,
                                             11'h000};
  localparam ctz_temp_t OTG_COLD_TAB [2] = '{11'h79c, 11'h738};
  localparam logic [1:0] OTG_HOT_OFF = 2'h3;

  localparam logic [13:0] PG_MV_TAB [8] = '{14'he74, 14'h1ce8, 14'h1f40,
    14'h28a0, 14'h2af8, 14'h3458, 14'h36b0, 14'h0000};
  localparam logic [2:0]  PG_RESERVED = 3'h7;
  localparam logic [11:0] BATLOW_MV_TAB [4] = '{12'hbb8, 12'haf0, 12'ha8c,
                                                12'h9c4};
  localparam logic [8:0]  VDROP_MV_TAB [4] = '{9'h12c, 9'h0c8, 9'h064, 9'h000};
  localparam logic [6:0]  ISCALE_PCT_TAB [4] = '{7'h00, 7'h14, 7'h28, 7'h64};
  localparam logic [2:0]  RATE_DIV_TAB [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
  localparam logic [6:0]  PCT_FULL = 7'h64;
  localparam logic [1:0]  ADJ_SUSPEND = 2'h0;
  localparam logic [1:0]  ADJ_KEEP    = 2'h3;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam longint CLK_KHZ           = 25000;
  localparam longint RST_HOLD_SHORT_MS = 11000;
  localparam longint RST_HOLD_LONG_MS  = 21000;
  localparam longint LP_EXIT_SHORT_MS  = 700;
  localparam longint LP_EXIT_LONG_MS   = 10500;
  // products fit in 30 bits, so the cut to 32 loses nothing
  localparam int unsigned RST_HOLD_SHORT_CYC =
    32'(RST_HOLD_SHORT_MS * CLK_KHZ);
  localparam int unsigned RST_HOLD_LONG_CYC  =
    32'(RST_HOLD_LONG_MS * CLK_KHZ);
  localparam int unsigned LP_EXIT_SHORT_CYC  =
    32'(LP_EXIT_SHORT_MS * CLK_KHZ);
  localparam int unsigned LP_EXIT_LONG_CYC   =
    32'(LP_EXIT_LONG_MS * CLK_KHZ);

endpackage

/* File: rtl/ctz_regs.sv */
// Purpose: thermal-zone configuration and charger status register bank.
// Assumes: register port driven by the two-wire engine on sys_clk_in;
//          power-stage status pins are asynchronous and synchronised here.
// Notes:   read data is registered, valid the cycle after rd_en_in.
//
// Notes on behaviour
// - hold bit picks 11 s or 21 s.
// - exit bit picks 700 ms or 10.5 s.
// - pull-down bit drives sys rail sink.
// - two-bit code picks precharge threshold voltage.
// - bypass forces normal zone, charge and otg.
// - reduced current is setting times ratio over rate.
// - otg hot limit 55/60/65, code 3 disables.
// - otg cold limit minus ten or minus twenty.
// - first threshold minus five or zero degrees.
// - sixth threshold 55 or 60 degrees.
// - second threshold 5 to 12.5 degrees.
// - third threshold 15 to 22.5 degrees.
// - fourth threshold 32.5 to 40 degrees.
// - fifth threshold 42.5 to 50 degrees.
// - voltage code drops target 300/200/100/none.
// - current code suspends, 20%, 40%, unchanged.
// - four zones each use their own settings.
// - power-good status follows bus above threshold.
// - conversion done only in one-shot mode.
// - min-system status only in forward mode.
// - regulation bits switch meaning in otg mode.
// - thermal and safety-timer status bits reported.
// - power-good threshold table, code 7 reserved.
// - register reset restores defaults except hold, exit and precharge fields, restarts timers.
`timescale 1ns/10ps
module ctz_regs
  import ctz_pkg::*;
#(
  parameter int unsigned HOLD_SHORT_CYC = RST_HOLD_SHORT_CYC,
  parameter int unsigned HOLD_LONG_CYC  = RST_HOLD_LONG_CYC,
  parameter int unsigned EXIT_SHORT_CYC = LP_EXIT_SHORT_CYC,
  parameter int unsigned EXIT_LONG_CYC  = LP_EXIT_LONG_CYC
)
(
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // register port from the serial engine
  input  wire logic [7:0]  addr_in,
  input  wire logic        wr_en_in,
  input  wire logic [7:0]  wr_data_in,
  input  wire logic        rd_en_in,
  output logic      [7:0]  rd_data_out,
  // reset events
  input  wire logic        reg_reset_cmd_in,
  input  wire logic        watchdog_expiry_in,
  output logic             reg_reset_done_out,
  output logic             timer_restart_out,
  // power-stage status pins
  input  wire ctz_pins_t   pins_in,
  // charge targets
  input  wire logic [12:0] charge_current_setting_in,
  input  wire logic [12:0] charge_voltage_target_in,
  output logic      [12:0] charge_current_out,
  output logic      [12:0] charge_voltage_out,
  output logic             charge_suspend_out,
  output logic             charge_allowed_out,
  output logic             otg_allowed_out,
  output ctz_zone_t        zone_out,
  // thresholds
  output ctz_temp_t        temp_threshold_out [6],
  output ctz_temp_t        boost_hot_limit_out,
  output logic             boost_hot_check_en_out,
  output ctz_temp_t        boost_cold_limit_out,
  output logic      [13:0] power_good_threshold_mv_out,
  output logic             power_good_threshold_valid_out,
  output logic      [11:0] precharge_to_fast_mv_out,
  output logic             sys_pulldown_en_out,
  output logic      [29:0] sys_reset_hold_cyc_out,
  output logic      [29:0] low_power_exit_cyc_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    ctz_regs_t   regs;
    ctz_pins_t   sync1;
    ctz_pins_t   sync2;
    logic [7:0]  rd_data;
    logic        done;
    logic [12:0] chg_current;
    logic [12:0] chg_voltage;
    logic        suspend;
  } ctz_state_t;

  ctz_state_t s_r;
  ctz_state_t s_nxt;
  logic [7:0] status_live;
  ctz_zone_t  zone_eff;
  logic [1:0] v_code;
  logic [1:0] i_code;
  logic [19:0] i_prod;
  logic [9:0]  i_div;

  function automatic logic [7:0] read_mux(input ctz_regs_t r,
                                          input logic [7:0] a,
                                          input logic [7:0] st);
    logic [7:0] d;
    d = 8'h00;
    if (a == CTZ_OFS_TIMING)
      d = r.timing;
    else if (a == CTZ_OFS_NTC_PRI)
      d = r.ntc_pri;
    else if (a == CTZ_OFS_NTC_SEL)
      d = r.ntc_sel;
    else if (a == CTZ_OFS_WARM)
      d = r.warm;
    else if (a == CTZ_OFS_COOL)
      d = r.cool;
    else if (a == CTZ_OFS_STATUS)
      d = st;
    return d;
  endfunction

  // ---------------------------------------------------------------
  // live status and zone
  // ---------------------------------------------------------------
  always_comb
  begin
    status_live = 8'h00;
    status_live[7] = s_r.sync2.vbus_above_pg;
    // continuous conversions never flag done
    status_live[6] = s_r.sync2.adc_oneshot_done
                     & ~s_r.sync2.adc_continuous;
    status_live[5] = s_r.sync2.thermal_reg;
    status_live[4] = s_r.sync2.forward_mode
                     & s_r.sync2.min_sys_reg;
    if (s_r.sync2.otg_mode)
    begin
      status_live[3] = s_r.sync2.otg_curr_reg;
      status_live[2] = s_r.sync2.otg_volt_reg;
    end
    else if (s_r.sync2.forward_mode)
    begin
      status_live[3] = s_r.sync2.input_curr_reg;
      status_live[2] = s_r.sync2.input_volt_reg;
    end
    status_live[1] = s_r.sync2.fast_timer_expired
                     | s_r.sync2.trickle_timer_expired
                     | s_r.sync2.precharge_timer_expired;
    status_live[0] = s_r.sync2.watchdog_expired;

    zone_eff = s_r.regs.ntc_pri.thermistor_bypass ? CTZ_ZONE_NORMAL
               : ctz_zone_t'(s_r.sync2.zone);
    v_code = ADJ_KEEP;
    i_code = ADJ_KEEP;
    case (zone_eff)
      CTZ_ZONE_WARM:
      begin
        v_code = s_r.regs.warm.outer_voltage_adjust;
        i_code = s_r.regs.warm.outer_current_adjust;
      end
      CTZ_ZONE_PREWARM:
      begin
        v_code = s_r.regs.warm.inner_voltage_adjust;
        i_code = s_r.regs.warm.inner_current_adjust;
      end
      CTZ_ZONE_COOL:
      begin
        v_code = s_r.regs.cool.outer_voltage_adjust;
        i_code = s_r.regs.cool.outer_current_adjust;
      end
      CTZ_ZONE_PRECOOL:
      begin
        v_code = s_r.regs.cool.inner_voltage_adjust;
        i_code = s_r.regs.cool.inner_current_adjust;
      end
      default:
      begin
        v_code = ADJ_KEEP;
        i_code = ADJ_KEEP;
      end
    endcase
    // foldback applies the rate divisor only to a reduced current
    i_prod = 20'(charge_current_setting_in * ISCALE_PCT_TAB[i_code]);
    i_div  = 10'(PCT_FULL
             * RATE_DIV_TAB[s_r.regs.ntc_pri.charge_rate_divisor]);
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sync1 = pins_in;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.done = 1'b0;
    if (wr_en_in)
    begin
      // the status register has no write path
      if (addr_in == CTZ_OFS_TIMING)
        s_nxt.regs.timing = ctz_timing_t'(wr_data_in);
      else if (addr_in == CTZ_OFS_NTC_PRI)
        s_nxt.regs.ntc_pri = ctz_ntc_pri_t'(wr_data_in);
      else if (addr_in == CTZ_OFS_NTC_SEL)
        s_nxt.regs.ntc_sel = ctz_ntc_sel_t'(wr_data_in);
      else if (addr_in == CTZ_OFS_WARM)
        s_nxt.regs.warm = ctz_zone_adj_t'(wr_data_in);
      else if (addr_in == CTZ_OFS_COOL)
        s_nxt.regs.cool = ctz_zone_adj_t'(wr_data_in);
    end
    if (watchdog_expiry_in)
    begin
      s_nxt.regs.timing.sys_pulldown_en =
        CTZ_REGS_RESET.timing.sys_pulldown_en;
      s_nxt.regs.ntc_pri.thermistor_bypass =
        CTZ_REGS_RESET.ntc_pri.thermistor_bypass;
    end
    if (reg_reset_cmd_in)
    begin
      // hold, exit and precharge fields survive a register reset
      s_nxt.regs = CTZ_REGS_RESET;
      s_nxt.regs.timing.sys_reset_hold_sel =
        s_r.regs.timing.sys_reset_hold_sel;
      s_nxt.regs.timing.low_power_exit_sel =
        s_r.regs.timing.low_power_exit_sel;
      s_nxt.regs.timing.precharge_to_fast_threshold =
        s_r.regs.timing.precharge_to_fast_threshold;
      s_nxt.done = 1'b1;
    end
    if (rd_en_in)
      s_nxt.rd_data = read_mux(s_r.regs, addr_in, status_live);
    s_nxt.suspend = (i_code == ADJ_SUSPEND);
    if (i_code == ADJ_KEEP)
      s_nxt.chg_current = charge_current_setting_in;
    else
      s_nxt.chg_current = 13'(i_prod / 20'(i_div));
    s_nxt.chg_voltage = charge_voltage_target_in
                        - 13'(VDROP_MV_TAB[v_code]);
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s_r <= '0;
      s_r.regs <= CTZ_REGS_RESET;
    end
    else
      s_r <= s_nxt;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rd_data_out        = s_r.rd_data;
  assign reg_reset_done_out = s_r.done;
  assign timer_restart_out  = s_r.done;
  assign charge_current_out = s_r.chg_current;
  assign charge_voltage_out = s_r.chg_voltage;
  assign charge_suspend_out = s_r.suspend;
  assign zone_out           = zone_eff;
  assign charge_allowed_out = ~s_r.suspend
    & (zone_eff != CTZ_ZONE_COLD) & (zone_eff != CTZ_ZONE_HOT);
  assign otg_allowed_out    =
    (zone_eff != CTZ_ZONE_COLD) & (zone_eff != CTZ_ZONE_HOT);

  assign temp_threshold_out[0] =
    TH1_TAB[s_r.regs.ntc_pri.temp_threshold_first];
  assign temp_threshold_out[1] =
    TH2_TAB[s_r.regs.ntc_sel.temp_threshold_second];
  assign temp_threshold_out[2] =
    TH3_TAB[s_r.regs.ntc_sel.temp_threshold_third];
  assign temp_threshold_out[3] =
    TH4_TAB[s_r.regs.ntc_sel.temp_threshold_fourth];
  assign temp_threshold_out[4] =
    TH5_TAB[s_r.regs.ntc_sel.temp_threshold_fifth];
  assign temp_threshold_out[5] =
    TH6_TAB[s_r.regs.ntc_pri.temp_threshold_sixth];
  assign boost_hot_limit_out =
    OTG_HOT_TAB[s_r.regs.ntc_pri.boost_hot_limit];
  assign boost_hot_check_en_out =
    s_r.regs.ntc_pri.boost_hot_limit != OTG_HOT_OFF;
  assign boost_cold_limit_out =
    OTG_COLD_TAB[s_r.regs.ntc_pri.boost_cold_limit];
  assign power_good_threshold_mv_out =
    PG_MV_TAB[s_r.regs.timing.power_good_threshold];
  assign power_good_threshold_valid_out =
    s_r.regs.timing.power_good_threshold != PG_RESERVED;
  assign precharge_to_fast_mv_out =
    BATLOW_MV_TAB[s_r.regs.timing.precharge_to_fast_threshold];
  assign sys_pulldown_en_out = s_r.regs.timing.sys_pulldown_en;
  assign sys_reset_hold_cyc_out = s_r.regs.timing.sys_reset_hold_sel
    ? 30'(HOLD_LONG_CYC) : 30'(HOLD_SHORT_CYC);
  assign low_power_exit_cyc_out = s_r.regs.timing.low_power_exit_sel
    ? 30'(EXIT_LONG_CYC) : 30'(EXIT_SHORT_CYC);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_pulldown_wd_clear: assert property (
    watchdog_expiry_in |=> !sys_pulldown_en_out)
    else $error("pull-down survived watchdog expiry");
  a_bypass_wd_clear: assert property (
    watchdog_expiry_in |=> !s_r.regs.ntc_pri.thermistor_bypass)
    else $error("bypass survived watchdog expiry");
  a_regrst_defaults: assert property (
    reg_reset_cmd_in |=> s_r.regs.ntc_sel == CTZ_REGS_RESET.ntc_sel
      && s_r.regs.warm == CTZ_REGS_RESET.warm && reg_reset_done_out
      ##1 !reg_reset_done_out || $past(reg_reset_cmd_in))
    else $error("register reset did not restore defaults");
  a_status_ro: assert property (
    wr_en_in && addr_in == CTZ_OFS_STATUS && !reg_reset_cmd_in
      && !watchdog_expiry_in |=> $stable(s_r.regs))
    else $error("status write changed a register");
  a_bypass_zone: assert property (
    s_r.regs.ntc_pri.thermistor_bypass |->
      zone_out == CTZ_ZONE_NORMAL && otg_allowed_out)
    else $error("bypass did not force normal zone");
  a_pg_follow: assert property (
    ##2 status_live[7] == $past(pins_in.vbus_above_pg, 2))
    else $error("power good status lags wrongly");
  a_adc_cont_zero: assert property (
    s_r.sync2.adc_continuous |-> !status_live[6])
    else $error("done flag set in continuous mode");
  a_suspend_zero: assert property (
    zone_eff == CTZ_ZONE_COOL && s_r.regs.cool.outer_current_adjust
      == ADJ_SUSPEND && $stable(zone_eff) |=> charge_suspend_out
      && !charge_allowed_out)
    else $error("cool zone suspend not applied");
  a_warm_vdrop: assert property (
    zone_eff == CTZ_ZONE_WARM && s_r.regs.warm.outer_voltage_adjust
      == 2'h0 |=> charge_voltage_out
      == $past(charge_voltage_target_in) - 13'h12c)
    else $error("warm zone voltage drop wrong");
  a_read_unmapped: assert property (
    rd_en_in && addr_in == 8'h1b |=> rd_data_out == 8'h00)
    else $error("unmapped read not zero");

  c_reg_reset:  cover property (reg_reset_cmd_in ##1 reg_reset_done_out);
  c_watchdog:   cover property (sys_pulldown_en_out ##1 watchdog_expiry_in);
  c_bypass:     cover property (s_r.regs.ntc_pri.thermistor_bypass
                                && s_r.sync2.zone == CTZ_ZONE_HOT);
  c_warm_fold:  cover property (zone_eff == CTZ_ZONE_WARM
                                && !charge_suspend_out);

endmodule

/* File: dv/ctz_host_model.sv */
// Purpose: host model that makes register accesses to the bank
// Assumes: requests change on the falling edge of sys_clk_in
// Notes:   one access at a time; read data is taken two edges later
`timescale 1ns/10ps
module ctz_host_model
(
  // clock
  input  wire logic       sys_clk_in,
  // register port
  output logic      [7:0] addr_out,
  output logic            wr_en_out,
  output logic      [7:0] wr_data_out,
  output logic            rd_en_out,
  input  wire logic [7:0] rd_data_in
);
  initial
  begin
    addr_out    = 8'h00;
    wr_en_out   = 1'b0;
    wr_data_out = 8'h00;
    rd_en_out   = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_in);
    addr_out    = a;
    wr_data_out = d;
    wr_en_out   = 1'b1;
    @(negedge sys_clk_in);
    wr_en_out   = 1'b0;
  endtask

  // data is registered, so wait past the taking edge before sampling
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk_in);
    addr_out  = a;
    rd_en_out = 1'b1;
    @(negedge sys_clk_in);
    rd_en_out = 1'b0;
    @(negedge sys_clk_in);
    d = rd_data_in;
  endtask
endmodule

/* File: dv/charger_thermal_zone_config_status_regs_tb_top.sv */
// Purpose: self-checking bench for the thermal-zone register bank
// Assumes: inputs change on the falling edge; small cycle counts
// Notes:   expected values are worked out from the field encodings
`timescale 1ns/10ps
module charger_thermal_zone_config_status_regs_tb_top
  import ctz_pkg::*;
();
  logic sys_clk_in, rst_n_in, wr_en_in, rd_en_in;
  logic [7:0] addr_in, wr_data_in, rd_data_out, rv;
  logic reg_reset_cmd_in, watchdog_expiry_in;
  logic reg_reset_done_out, timer_restart_out;
  ctz_pins_t pins_in;
  logic [12:0] charge_current_setting_in, charge_voltage_target_in;
  logic [12:0] charge_current_out, charge_voltage_out;
  logic charge_suspend_out, charge_allowed_out, otg_allowed_out;
  ctz_zone_t zone_out;
  ctz_temp_t temp_threshold_out [6];
  ctz_temp_t boost_hot_limit_out, boost_cold_limit_out;
  logic boost_hot_check_en_out, power_good_threshold_valid_out;
  logic [13:0] power_good_threshold_mv_out;
  logic [11:0] precharge_to_fast_mv_out;
  logic sys_pulldown_en_out;
  logic [29:0] sys_reset_hold_cyc_out, low_power_exit_cyc_out;
  int bad_count = 0;
  int checks_done = 0;
  logic [7:0] ofs [6] = '{8'h1a, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20};
  logic [7:0] dfl [6] = '{8'h00, 8'h0f, 8'h85, 8'h7f, 8'hdf, 8'h00};
  int base [4] = '{50, 150, 325, 425};

  ctz_host_model host_u (.sys_clk_in, .addr_out(addr_in),
    .wr_en_out(wr_en_in), .wr_data_out(wr_data_in),
    .rd_en_out(rd_en_in), .rd_data_in(rd_data_out));

  ctz_regs #(.HOLD_SHORT_CYC(11), .HOLD_LONG_CYC(21),
    .EXIT_SHORT_CYC(7), .EXIT_LONG_CYC(105)) dut_u (
    .sys_clk_in, .rst_n_in, .addr_in, .wr_en_in, .wr_data_in,
    .rd_en_in, .rd_data_out, .reg_reset_cmd_in, .watchdog_expiry_in,
    .reg_reset_done_out, .timer_restart_out, .pins_in,
    .charge_current_setting_in, .charge_voltage_target_in,
    .charge_current_out, .charge_voltage_out, .charge_suspend_out,
    .charge_allowed_out, .otg_allowed_out, .zone_out,
    .temp_threshold_out, .boost_hot_limit_out, .boost_hot_check_en_out,
    .boost_cold_limit_out, .power_good_threshold_mv_out,
    .power_good_threshold_valid_out, .precharge_to_fast_mv_out,
    .sys_pulldown_en_out, .sys_reset_hold_cyc_out,
    .low_power_exit_cyc_out);

  initial
  begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // a zone change needs two sync edges and one output register
  task automatic zone_chk(input ctz_zone_t z, input int i, input int v,
                          input logic s);
    pins_in.zone = z;
    repeat (4) @(negedge sys_clk_in);
    chk(charge_current_out, i);
    chk(charge_voltage_out, v);
    chk(charge_suspend_out, s);
    chk(charge_allowed_out, !s);
  endtask

  initial
  begin
    #100000;
    bad_count++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    rst_n_in = 1'b0;
    pins_in = '0;
    reg_reset_cmd_in = 1'b0;
    watchdog_expiry_in = 1'b0;
    charge_current_setting_in = 13'h3e8;
    charge_voltage_target_in = 13'h1068;
    repeat (6) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      host_u.rd(ofs[i], rv);
      chk(rv, dfl[i]);
    end
    chk(sys_reset_hold_cyc_out, 11);
    chk(low_power_exit_cyc_out, 7);
    chk(precharge_to_fast_mv_out, 3000);
    host_u.wr(8'h20, 8'hff);
    host_u.rd(8'h20, rv);
    chk(rv, 8'h00);
    host_u.wr(8'h1b, 8'hff);
    host_u.rd(8'h1b, rv);
    chk(rv, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      host_u.wr(8'h1d, {4{c[1:0]}});
      for (int k = 1; k < 5; k++)
        chk(temp_threshold_out[k], base[k-1] + 25 * c);
    end
    host_u.wr(8'h1c, 8'h00);
    chk(temp_threshold_out[0], ctz_temp_t'(-50));
    chk(temp_threshold_out[5], 550);
    chk(boost_hot_limit_out, 550);
    chk(boost_cold_limit_out, ctz_temp_t'(-100));
    host_u.wr(8'h1c, 8'h9f);
    chk(boost_hot_check_en_out, 1'b0);
    chk(boost_cold_limit_out, ctz_temp_t'(-200));
    chk(temp_threshold_out[5], 600);
    host_u.wr(8'h1a, 8'hff);
    chk(sys_reset_hold_cyc_out, 21);
    chk(low_power_exit_cyc_out, 105);
    chk(precharge_to_fast_mv_out, 2500);
    chk(sys_pulldown_en_out, 1'b1);
    chk(power_good_threshold_valid_out, 1'b0);
    pins_in.zone = CTZ_ZONE_HOT;
    repeat (3) @(negedge sys_clk_in);
    chk(zone_out, CTZ_ZONE_NORMAL);
    chk(otg_allowed_out, 1'b1);
    watchdog_expiry_in = 1'b1;
    @(negedge sys_clk_in);
    watchdog_expiry_in = 1'b0;
    chk(sys_pulldown_en_out, 1'b0);
    host_u.rd(8'h1c, rv);
    chk(rv, 8'h1f);
    chk(zone_out, CTZ_ZONE_HOT);
    chk(otg_allowed_out, 1'b0);
    reg_reset_cmd_in = 1'b1;
    @(negedge sys_clk_in);
    reg_reset_cmd_in = 1'b0;
    chk(reg_reset_done_out, 1'b1);
    chk(timer_restart_out, 1'b1);
    @(negedge sys_clk_in);
    chk(reg_reset_done_out, 1'b0);
    host_u.rd(8'h1a, rv);
    chk(rv, 8'h1b);
    chk(power_good_threshold_mv_out, 3700);
    chk(power_good_threshold_valid_out, 1'b1);
    host_u.rd(8'h1d, rv);
    chk(rv, 8'h85);
    host_u.wr(8'h1e, 8'h1a);
    zone_chk(CTZ_ZONE_WARM, 200, 3900, 1'b0);
    zone_chk(CTZ_ZONE_PREWARM, 400, 4100, 1'b0);
    host_u.wr(8'h1c, 8'h4f);
    zone_chk(CTZ_ZONE_PREWARM, 100, 4100, 1'b0);
    host_u.wr(8'h1f, 8'h00);
    zone_chk(CTZ_ZONE_COOL, 0, 3900, 1'b1);
    pins_in = '0;
    pins_in.vbus_above_pg = 1'b1;
    pins_in.adc_oneshot_done = 1'b1;
    pins_in.thermal_reg = 1'b1;
    pins_in.fast_timer_expired = 1'b1;
    pins_in.forward_mode = 1'b1;
    pins_in.min_sys_reg = 1'b1;
    pins_in.input_curr_reg = 1'b1;
    // pins pass two sync flops before a read can see them
    repeat (2) @(negedge sys_clk_in);
    host_u.rd(8'h20, rv);
    chk(rv, 8'hfa);
    pins_in.forward_mode = 1'b0;
    pins_in.otg_mode = 1'b1;
    pins_in.otg_volt_reg = 1'b1;
    pins_in.adc_continuous = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    host_u.rd(8'h20, rv);
    chk(rv, 8'ha6);
    finish_test();
  end
endmodule
